// ---- testbench/mdc_core_model.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Core side of the coprocessor instruction interface
// ---------------------------------------------------------------
module mdc_core_model (
  input wire logic mclk_i,
  input wire logic [15:0] result_i,
  input wire logic busy_i,
  output logic clk_en_o,
  output logic mode_wr_o,
  output logic [6:0] mode_data_o,
  output logic load_o,
  output logic operate_o,
  output logic [15:0] opa_o,
  output logic [15:0] opb_o
);
  // Idle levels; operands are flipped after use so stale data never looks valid
  initial begin
    clk_en_o = 1'b1;
    mode_wr_o = 1'b0;
    mode_data_o = 7'h55;
    load_o = 1'b0;
    operate_o = 1'b0;
    opa_o = 16'ha5a5;
    opb_o = 16'h5a5a;
  end

  // Mode write: one strobe, seven bits from a register or an immediate
  task automatic wr_mode(input logic [6:0] m);
    @(posedge mclk_i);
    mode_wr_o <= 1'b1;
    mode_data_o <= m;
    @(posedge mclk_i);
    mode_wr_o <= 1'b0;
    mode_data_o <= ~m;
  endtask

  // Mode write with the clock enable low: the coprocessor must ignore it
  task automatic wr_mode_frozen(input logic [6:0] m);
    @(posedge mclk_i);
    clk_en_o <= 1'b0;
    mode_wr_o <= 1'b1;
    mode_data_o <= m;
    @(posedge mclk_i);
    clk_en_o <= 1'b1;
    mode_wr_o <= 1'b0;
    mode_data_o <= ~m;
  endtask

  // Load-result: 32 bits travel as {opa, opb}, high word first
  task automatic load_data(input logic [31:0] d);
    @(posedge mclk_i);
    load_o <= 1'b1;
    opa_o <= d[31:16];
    opb_o <= d[15:0];
    @(posedge mclk_i);
    load_o <= 1'b0;
    opa_o <= ~d[31:16];
    opb_o <= ~d[15:0];
  endtask

  // Operate: answer taken mid-cycle; a divide stall is waited out under a bound, never re-issued
  task automatic operate(input logic [31:0] d, output logic [15:0] r, output int n);
    @(posedge mclk_i);
    operate_o <= 1'b1;
    opa_o <= d[31:16];
    opb_o <= d[15:0];
    n = 0;
    @(negedge mclk_i);
    while (busy_i !== 1'b0 && n < 40) begin
      @(posedge mclk_i);
      operate_o <= 1'b0;
      n++;
      @(negedge mclk_i);
    end
    r = result_i;
    @(posedge mclk_i);
    operate_o <= 1'b0;
    opa_o <= ~d[31:16];
    opb_o <= ~d[15:0];
  endtask
endmodule

// ---- testbench/tb_mul_div_mac_coprocessor.sv ----
`timescale 1ns/10ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end
module tb_mul_div_mac_coprocessor;
  import mdc_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic clk_en, mode_wr, load, operate, busy;
  logic [6:0] mode_data;
  logic [15:0] opa, opb, result;
  logic [3:0] flags;
  logic [15:0] r;
  logic [15:0] tbl [4] = '{16'hbeef, 16'hdead, 16'hf00d, 16'hcafe};
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int last_n;

  // ---------------------------------------------------------------
  // Clock, design and core model
  // ---------------------------------------------------------------
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  mdc_core mdc_core_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .clk_en_i(clk_en), .mode_wr_i(mode_wr),
    .mode_data_i(mode_data), .load_i(load), .operate_i(operate), .opa_i(opa), .opb_i(opb),
    .result_o(result), .carry_overflow_zero_negative_flags_o(flags), .busy_o(busy));

  mdc_core_model mdc_core_model_i (.mclk_i(mclk_i), .result_i(result), .busy_i(busy), .clk_en_o(clk_en),
    .mode_wr_o(mode_wr), .mode_data_o(mode_data), .load_o(load), .operate_o(operate), .opa_o(opa),
    .opb_o(opb));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic run(input logic [6:0] m, input logic [31:0] d, input logic [15:0] exp, input string what);
    mdc_core_model_i.wr_mode(m);
    mdc_core_model_i.operate(d, r, last_n);
    // Flags are registered on the operate edge; look only once they have settled
    @(negedge mclk_i);
    `CHK(what, exp, r)
  endtask

  task automatic ld(input logic [6:0] m, input logic [31:0] d);
    mdc_core_model_i.wr_mode(m);
    mdc_core_model_i.load_data(d);
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(negedge mclk_i);
    `CHK("reset result", 16'h0000, result)
    `CHK("reset busy", 1'b0, busy)
    run(7'h04, 32'hffffffff, 16'h0001, "mulu lo");
    `CHK("mul flags", MDC_FLAGS_CLR, flags)
    run(7'h13, 32'h0, 16'hfffe, "mulu hi");
    run(7'h14, 32'hffffffff, 16'hfffe, "mulu hi direct");
    run(7'h05, 32'hffff0002, 16'hfffe, "muls lo");
    run(7'h15, 32'hffff0002, 16'hffff, "muls hi direct");
    $display("test multiply done");
    ld(7'h01, 32'h12340010);
    run(7'h13, 32'h0, 16'h0000, "load16 upper");
    run(7'h06, 32'h00030004, 16'h001c, "macu lo");
    `CHK("macu flags", MDC_FLAGS_CLR, flags)
    ld(7'h02, 32'h7fffffff);
    run(7'h07, 32'h00010001, 16'h0000, "macs lo");
    `CHK("macs overflow", MDC_FLAGS_OVF, flags)
    run(7'h13, 32'h0, 16'h8000, "macs hi kept");
    run(7'h04, 32'h00020003, 16'h0006, "mul after mac");
    `CHK("flags cleared", MDC_FLAGS_CLR, flags)
    $display("test mac done");
    ld(7'h02, 32'hdeadbeef);
    ld(7'h0a, 32'hcafef00d);
    for (int s = 0; s < 4; s++) begin
      run({s[2:0], 4'h3}, 32'h0, tbl[s], "half select");
    end
    run(7'h43, 32'h0, 16'h0000, "reserved select");
    run(7'h1b, 32'h0, 16'hdead, "reserved op");
    mdc_core_model_i.wr_mode(7'h00);
    run(7'h13, 32'h0, 16'h0000, "clear r0");
    run(7'h33, 32'h0, 16'h0000, "clear r1");
    $display("test load and clear done");
    // Divisors are never zero: the result of that case is undefined
    ld(7'h02, 32'h000186a0);
    run(7'h08, 32'h00000007, 16'h37cd, "divu quotient");
    `CHK("div stall", 1'b1, (last_n >= 17 && last_n <= 20))
    run(7'h13, 32'h0, 16'h0000, "divu quo hi");
    run(7'h23, 32'h0, 16'h0005, "divu rem lo");
    ld(7'h02, 32'hffffff9c);
    run(7'h19, 32'h00000007, 16'hffff, "divs quo hi");
    run(7'h03, 32'h0, 16'hfff2, "divs quo lo");
    run(7'h23, 32'h0, 16'hfffe, "divs rem lo");
    run(7'h33, 32'h0, 16'hffff, "divs rem hi");
    $display("test divide done");
    // A clear written while the clock enable is low must not reach the results
    mdc_core_model_i.wr_mode_frozen(7'h00);
    run(7'h33, 32'h0, 16'hffff, "frozen clear ignored");
    // Reset again mid-run: results and mode fall back to their reset values
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(negedge mclk_i);
    `CHK("reset again result", 16'h0000, result)
    `CHK("reset again busy", 1'b0, busy)
    $display("test freeze and reset done");
    test_done();
  end
endmodule

// ---- verilog/mdc_core.sv ----
`timescale 1ns/10ps
module mdc_core import mdc_pkg::*; (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic mode_wr_i,
  input wire logic [6:0] mode_data_i,
  input wire logic load_i,
  input wire logic operate_i,
  input wire logic [15:0] opa_i,
  input wire logic [15:0] opb_i,
  output logic [15:0] result_o,
  output logic [3:0] carry_overflow_zero_negative_flags_o,
  output logic busy_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {MDC_IDLE, MDC_DIV, MDC_FIX} mdc_phase_t;
  typedef struct packed {
    logic [6:0] mode;
    logic [31:0] result_reg_zero;
    logic [31:0] result_reg_one;
    logic [3:0] flags;
    mdc_phase_t phase;
    logic [3:0] cnt;
    logic [31:0] den;
    logic neg_q;
    logic neg_r;
  } mdc_state_t;

  mdc_state_t st_q;
  mdc_state_t st_d;
  logic [3:0] op;
  logic [2:0] osel;
  logic [31:0] prod_u;
  logic [31:0] prod_s;
  logic [31:0] prod;
  logic [31:0] mac_sum;
  logic mac_ovf;
  logic [31:0] divisor;
  logic signed_div;
  logic [31:0] step_rem;
  logic [31:0] step_quo;
  logic [31:0] out_r0;
  logic [31:0] out_r1;

  assign op = st_q.mode[MDC_OP_MSB:MDC_OP_LSB];
  assign osel = st_q.mode[MDC_OUT_MSB:MDC_OUT_LSB];

  // ---------------------------------------------------------------
  // Arithmetic
  // ---------------------------------------------------------------
  // Products are formed fresh every cycle so multiply needs no extra state
  assign prod_u = {16'h0000, opa_i} * {16'h0000, opb_i};
  // Operands widened first so the signed product never depends on context width
  assign prod_s = $signed({{16{opa_i[15]}}, opa_i}) * $signed({{16{opb_i[15]}}, opb_i});
  assign prod = (op == MDC_OP_MULS || op == MDC_OP_MACS) ? prod_s : prod_u;
  assign mac_sum = prod + st_q.result_reg_zero;
  // Same-sign addends with a differing sum sign mean signed overflow
  assign mac_ovf = (prod[31] == st_q.result_reg_zero[31]) && (mac_sum[31] != prod[31]);
  assign divisor = {opa_i, opb_i};
  assign signed_div = (op == MDC_OP_DIVS);

  // Magnitude divide: result_reg_one holds partial remainder, result_reg_zero the shifting quotient
  mdc_div_step u_step (
    .rem_i(st_q.result_reg_one),
    .quo_i(st_q.result_reg_zero),
    .den_i(st_q.den),
    .rem_o(step_rem),
    .quo_o(step_quo)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q.phase)
      MDC_IDLE: begin
        if (mode_wr_i) begin
          st_d.mode = mode_data_i;
          if (mode_data_i[MDC_OP_MSB:MDC_OP_LSB] == MDC_OP_CLEAR) begin
            st_d.result_reg_zero = 32'h0000_0000;
            st_d.result_reg_one = 32'h0000_0000;
          end
        end else if (load_i) begin
          if (op == MDC_OP_LOAD16) begin
            st_d.result_reg_zero = {16'h0000, opb_i};
          end else if (op == MDC_OP_LOAD32_R0) begin
            st_d.result_reg_zero = divisor;
          end else if (op == MDC_OP_LOAD32_R1) begin
            st_d.result_reg_one = divisor;
          end
        end else if (operate_i) begin
          case (op)
            MDC_OP_MULU, MDC_OP_MULS: begin
              st_d.result_reg_zero = prod;
              st_d.flags = MDC_FLAGS_CLR;
            end
            MDC_OP_MACU, MDC_OP_MACS: begin
              st_d.result_reg_zero = mac_sum;
              st_d.flags = (op == MDC_OP_MACS && mac_ovf) ? MDC_FLAGS_OVF : MDC_FLAGS_CLR;
            end
            MDC_OP_DIVU, MDC_OP_DIVS: begin
              // Operands are made positive first; signs restored in MDC_FIX
              st_d.neg_q = signed_div && (st_q.result_reg_zero[31] ^ divisor[31]);
              st_d.neg_r = signed_div && st_q.result_reg_zero[31];
              st_d.result_reg_zero = (signed_div && st_q.result_reg_zero[31]) ? 32'(-st_q.result_reg_zero) : st_q.result_reg_zero;
              st_d.den = (signed_div && divisor[31]) ? 32'(-divisor) : divisor;
              st_d.result_reg_one = 32'h0000_0000;
              st_d.cnt = 4'h0;
              st_d.flags = MDC_FLAGS_CLR;
              st_d.phase = MDC_DIV;
            end
            default: begin
              st_d.result_reg_zero = st_q.result_reg_zero;
            end
          endcase
        end
      end
      MDC_DIV: begin
        // Zero divisor yields all-ones quotient before the sign fix; not trapped, the core must avoid it
        st_d.result_reg_zero = step_quo;
        st_d.result_reg_one = step_rem;
        st_d.cnt = 4'(st_q.cnt + 4'h1);
        if (st_q.cnt == 4'(MDC_DIV_STEPS - 1)) begin
          st_d.phase = MDC_FIX;
        end
      end
      MDC_FIX: begin
        st_d.result_reg_zero = st_q.neg_q ? 32'(-st_q.result_reg_zero) : st_q.result_reg_zero;
        st_d.result_reg_one = st_q.neg_r ? 32'(-st_q.result_reg_one) : st_q.result_reg_one;
        st_d.phase = MDC_IDLE;
      end
      default: begin
        st_d.phase = MDC_IDLE;
      end
    endcase
  end

  // Registers freeze whole while the clock enable is low
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= '{mode: MDC_MODE_RST, result_reg_zero: 32'h0, result_reg_one: 32'h0, flags: 4'h0, phase: MDC_IDLE,
               cnt: 4'h0, den: 32'h0, neg_q: 1'b0, neg_r: 1'b0};
    end else if (clk_en_i) begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Answer to the core
  // ---------------------------------------------------------------
  // One-cycle ops answer with the value being written this cycle
  always_comb begin
    out_r0 = st_q.result_reg_zero;
    out_r1 = st_q.result_reg_one;
    if (operate_i && st_q.phase == MDC_IDLE) begin
      if (op == MDC_OP_MULU || op == MDC_OP_MULS) begin
        out_r0 = prod;
      end else if (op == MDC_OP_MACU || op == MDC_OP_MACS) begin
        out_r0 = mac_sum;
      end
    end
    case (osel)
      MDC_OUT_R0_LO: result_o = out_r0[15:0];
      MDC_OUT_R0_HI: result_o = out_r0[31:16];
      MDC_OUT_R1_LO: result_o = out_r1[15:0];
      MDC_OUT_R1_HI: result_o = out_r1[31:16];
      default: result_o = 16'h0000;
    endcase
  end

  // Division stalls from the operate cycle until the sign fix has settled
  assign busy_o = (st_q.phase != MDC_IDLE) ||
                  (operate_i && (op == MDC_OP_DIVU || op == MDC_OP_DIVS));
  assign carry_overflow_zero_negative_flags_o = st_q.flags;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_clear_on_write;
    @(posedge mclk_i) disable iff (!nrst_i)
      (clk_en_i && st_q.phase == MDC_IDLE && mode_wr_i && mode_data_i[3:0] == MDC_OP_CLEAR)
      |=> (st_q.result_reg_zero == 32'h0 && st_q.result_reg_one == 32'h0);
  endproperty
  a_clear_on_write: assert property (p_clear_on_write) else $error("clear mode did not zero results");

  property p_load16;
    @(posedge mclk_i) disable iff (!nrst_i)
      (clk_en_i && st_q.phase == MDC_IDLE && !mode_wr_i && load_i && op == MDC_OP_LOAD16)
      |=> (st_q.result_reg_zero == {16'h0000, $past(opb_i)});
  endproperty
  a_load16: assert property (p_load16) else $error("16-bit load wrong");

  property p_mul_one_cycle;
    @(posedge mclk_i) disable iff (!nrst_i)
      (clk_en_i && st_q.phase == MDC_IDLE && !mode_wr_i && !load_i && operate_i && op == MDC_OP_MULU)
      |=> (st_q.result_reg_zero == $past(opa_i) * $past(opb_i) && st_q.flags == 4'h0);
  endproperty
  a_mul_one_cycle: assert property (p_mul_one_cycle) else $error("unsigned product wrong");

  property p_mac_ovf;
    @(posedge mclk_i) disable iff (!nrst_i)
      (clk_en_i && st_q.phase == MDC_IDLE && !mode_wr_i && !load_i && operate_i && op == MDC_OP_MACU)
      |=> (st_q.flags == 4'h0);
  endproperty
  a_mac_ovf: assert property (p_mac_ovf) else $error("unsigned mac set overflow");

  property p_div_time;
    @(posedge mclk_i) disable iff (!nrst_i)
      (clk_en_i && $rose(busy_o)) |-> ##[17:20] !busy_o;
  endproperty
  a_div_time: assert property (p_div_time) else $error("division length out of range");

  property p_div_unsigned;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_q.phase == MDC_FIX && !st_q.neg_q && !st_q.neg_r && st_q.den != 32'h0)
      |-> (st_q.result_reg_one < st_q.den);
  endproperty
  a_div_unsigned: assert property (p_div_unsigned) else $error("remainder not below divisor");

  property p_hold;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_q.phase == MDC_IDLE && !mode_wr_i && !load_i && !operate_i) |=> $stable(st_q.result_reg_zero);
  endproperty
  a_hold: assert property (p_hold) else $error("result zero changed while idle");

  property p_out_sel;
    @(posedge mclk_i) disable iff (!nrst_i)
      (!operate_i && osel == MDC_OUT_R1_HI) |-> (result_o == st_q.result_reg_one[31:16]);
  endproperty
  a_out_sel: assert property (p_out_sel) else $error("output half select wrong");
endmodule

// ---- verilog/mdc_div_step.sv ----
`timescale 1ns/10ps
// Two restoring-division steps per call: shifts one remainder/quotient pair twice
module mdc_div_step (
  input wire logic [31:0] rem_i,
  input wire logic [31:0] quo_i,
  input wire logic [31:0] den_i,
  output logic [31:0] rem_o,
  output logic [31:0] quo_o
);
  logic [32:0] t1;
  logic [31:0] r1;
  logic [31:0] q1;
  logic [32:0] t2;

  // Each of the two bits: trial subtract, restore on borrow
  always_comb begin
    t1 = {rem_i, quo_i[31]} - {1'b0, den_i};
    r1 = t1[32] ? {rem_i[30:0], quo_i[31]} : t1[31:0];
    q1 = {quo_i[30:0], ~t1[32]};
    t2 = {r1, q1[31]} - {1'b0, den_i};
    rem_o = t2[32] ? {r1[30:0], q1[31]} : t2[31:0];
    quo_o = {q1[30:0], ~t2[32]};
  end
endmodule

// ---- verilog/mdc_pkg.sv ----
package mdc_pkg;
  // ---------------------------------------------------------------
  // Mode setting layout
  // ---------------------------------------------------------------
  localparam int MDC_MODE_W = 7;
  localparam int MDC_OUT_MSB = 6;
  localparam int MDC_OUT_LSB = 4;
  localparam int MDC_OP_MSB = 3;
  localparam int MDC_OP_LSB = 0;
  localparam logic [6:0] MDC_MODE_RST = 7'h03;

  // ---------------------------------------------------------------
  // Output selections
  // ---------------------------------------------------------------
  localparam logic [2:0] MDC_OUT_R0_LO = 3'h0;
  localparam logic [2:0] MDC_OUT_R0_HI = 3'h1;
  localparam logic [2:0] MDC_OUT_R1_LO = 3'h2;
  localparam logic [2:0] MDC_OUT_R1_HI = 3'h3;

  // ---------------------------------------------------------------
  // Operation modes
  // ---------------------------------------------------------------
  localparam logic [3:0] MDC_OP_CLEAR = 4'h0;
  localparam logic [3:0] MDC_OP_LOAD16 = 4'h1;
  localparam logic [3:0] MDC_OP_LOAD32_R0 = 4'h2;
  localparam logic [3:0] MDC_OP_READ = 4'h3;
  localparam logic [3:0] MDC_OP_MULU = 4'h4;
  localparam logic [3:0] MDC_OP_MULS = 4'h5;
  localparam logic [3:0] MDC_OP_MACU = 4'h6;
  localparam logic [3:0] MDC_OP_MACS = 4'h7;
  localparam logic [3:0] MDC_OP_DIVU = 4'h8;
  localparam logic [3:0] MDC_OP_DIVS = 4'h9;
  localparam logic [3:0] MDC_OP_LOAD32_R1 = 4'ha;

  // ---------------------------------------------------------------
  // Timing and flag values
  // ---------------------------------------------------------------
  localparam int MDC_DIV_STEPS = 16;
  localparam logic [3:0] MDC_FLAGS_CLR = 4'h0;
  localparam logic [3:0] MDC_FLAGS_OVF = 4'h4;
endpackage
